// >>> src/pwp_pkg.sv
/*
 * Package for the write-protect flag block of one peripheral bridge.
 * Holds register offsets, flag positions, reset values and bus widths.
 * Assumes a single synchronous clock domain and word-wide register access.
 */
package pwp_pkg;

	// ****************************************************************
	// Bus geometry
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFF_PROTECT_CLEAR = 8'h00;
	localparam logic [7:0] OFF_PROTECT_SET = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFF_LAST_FAULT = 8'h10;

	// ****************************************************************
	// Flag positions
	// ****************************************************************
	localparam int EVENT_SYSTEM_BIT = 1;
	localparam int SERIAL_LO = 2;
	localparam int SERIAL_HI = 7;
	localparam int TIMER_LO = 8;
	localparam int TIMER_HI = 15;
	localparam int ADC_BIT = 16;
	localparam int COMPARATOR_BIT = 17;
	localparam int DAC_BIT = 18;
	localparam int TOUCH_BIT = 19;

	// Positions that hold a peripheral flag; all others read as zero.
	localparam logic [31:0] FLAG_MASK = 32'h000f_fffe;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] PROTECT_RESET = 32'h0080_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ****************************************************************
	// Interrupt status layout
	// ****************************************************************
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_BITS = 1;

endpackage : pwp_pkg

// >>> src/pwp_flags.sv
/*
 * Shared protection flag store, seen through both the clear and set windows.
 * Assumes one-cycle write pulses from the register decoder on the same clock.
 */
`timescale 1ns/1ps

module pwp_flags #(
	parameter int WIDTH = 32,
	parameter logic [31:0] RESET_VALUE = 32'h0080_0000,
	parameter logic [31:0] VALID_MASK = 32'h000f_fffe
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear_we,
	input wire logic set_we,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] flags
);
	import pwp_pkg::*;

	// Refuse flag word widths other than the one that the masks are built for.
	if (WIDTH != 32) begin : g_bad_width
		$error("pwp_flags supports a 32-bit flag word only.");
	end

	// ****************************************************************
	// Flag update
	// ****************************************************************
	// Ones clear or set their flag; zeros keep it, so no read-modify-write is needed.
	always_ff @(posedge clk) begin
		if (rst) begin
			flags <= RESET_VALUE;
		end else if (clear_we) begin
			flags <= flags & ~(wdata & VALID_MASK);
		end else if (set_we) begin
			flags <= flags | (wdata & VALID_MASK);
		end
	end

endmodule : pwp_flags

// >>> src/pwp_guard.sv
/*
 * Write gate for the peripheral side: drops writes to protected peripherals.
 * Assumes the peripheral select is one-hot in flag positions and on the same clock.
 */
`timescale 1ns/1ps

module pwp_guard #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] flags,
	input wire logic periph_we,
	input wire logic [WIDTH-1:0] periph_sel,
	output logic periph_we_gated,
	output logic periph_err
);

	// ****************************************************************
	// Gate and error
	// ****************************************************************
	// A hit on a protected flag kills the write and flags a bus error instead.
	always_ff @(posedge clk) begin
		if (rst) begin
			periph_we_gated <= 1'b0;
			periph_err <= 1'b0;
		end else begin
			periph_we_gated <= periph_we & ~|(periph_sel & flags);
			periph_err <= periph_we & |(periph_sel & flags);
		end
	end

endmodule : pwp_guard

// >>> src/pwp_top.sv
/*
 * Peripheral write-protect controller for one bridge: protect clear/set
 * windows over one shared flag word, a write gate, and an error interrupt.
 * Assumes a plain register port and peripheral write requests on clk.
 */
`timescale 1ns/1ps

module pwp_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [pwp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pwp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [pwp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic periph_we,
	input wire logic [pwp_pkg::DATA_W-1:0] periph_sel,
	output logic periph_we_gated,
	output logic periph_err,
	output logic [pwp_pkg::DATA_W-1:0] protect_flags,
	output logic irq
);
	import pwp_pkg::*;

	logic [DATA_W-1:0] flags;
	logic clear_we;
	logic set_we;
	logic err_pulse;
	logic [IRQ_BITS-1:0] irq_status_reg;
	logic [IRQ_BITS-1:0] irq_status_next;
	logic [IRQ_BITS-1:0] irq_mask_reg;
	logic [DATA_W-1:0] last_fault_reg;

	// Decode of a write to one offset, used for several registers.
	function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		wr_hit = (a == off);
	endfunction : wr_hit

	// ****************************************************************
	// Register write decode
	// ****************************************************************
	// Strobes into the shared flag store.
	assign clear_we = reg_we & wr_hit(reg_addr, OFF_PROTECT_CLEAR);
	assign set_we = reg_we & wr_hit(reg_addr, OFF_PROTECT_SET);

	pwp_flags #(
		.WIDTH(DATA_W),
		.RESET_VALUE(PROTECT_RESET),
		.VALID_MASK(FLAG_MASK)
	) u_flags (
		.clk(clk),
		.rst(rst),
		.clear_we(clear_we),
		.set_we(set_we),
		.wdata(reg_wdata),
		.flags(flags)
	);

	pwp_guard #(
		.WIDTH(DATA_W)
	) u_guard (
		.clk(clk),
		.rst(rst),
		.flags(flags),
		.periph_we(periph_we),
		.periph_sel(periph_sel),
		.periph_we_gated(periph_we_gated),
		.periph_err(err_pulse)
	);

	// ****************************************************************
	// Error output and fault capture
	// ****************************************************************
	// Error pulse is re-registered so the port is a flop; last fault keeps the select.
	always_ff @(posedge clk) begin
		if (rst) begin
			periph_err <= 1'b0;
		end else begin
			periph_err <= err_pulse;
		end
	end

	// Capture which peripheral select caused the most recent refused write.
	always_ff @(posedge clk) begin
		if (rst) begin
			last_fault_reg <= ZERO_WORD;
		end else if (periph_we & |(periph_sel & flags)) begin
			last_fault_reg <= periph_sel & FLAG_MASK;
		end
	end

	// ****************************************************************
	// Interrupt status and mask
	// ****************************************************************
	// A new fault wins over a same-cycle write-one-to-clear.
	always_comb begin
		irq_status_next = irq_status_reg;
		if (reg_we && wr_hit(reg_addr, OFF_IRQ_STATUS)) begin
			irq_status_next = irq_status_next & ~reg_wdata[IRQ_BITS-1:0];
		end
		if (err_pulse) begin
			irq_status_next[IRQ_FAULT_BIT] = 1'b1;
		end
	end

	// Status holds sticky events.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	// Mask enables status bits onto the interrupt line.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_reg <= '0;
		end else if (reg_we && wr_hit(reg_addr, OFF_IRQ_MASK)) begin
			irq_mask_reg <= reg_wdata[IRQ_BITS-1:0];
		end
	end

	// Level interrupt, registered.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_next & irq_mask_reg);
		end
	end

	// ****************************************************************
	// Flag mirror output
	// ****************************************************************
	// Registered copy of the flags; bit 23 reset value stays outside the flag positions.
	always_ff @(posedge clk) begin
		if (rst) begin
			protect_flags <= ZERO_WORD;
		end else begin
			protect_flags[TIMER_HI:TIMER_LO] <= flags[TIMER_HI:TIMER_LO];
			protect_flags[SERIAL_HI:SERIAL_LO] <= flags[SERIAL_HI:SERIAL_LO];
			protect_flags[EVENT_SYSTEM_BIT] <= flags[EVENT_SYSTEM_BIT];
			protect_flags[TOUCH_BIT:ADC_BIT] <= flags[TOUCH_BIT:ADC_BIT];
			protect_flags[0] <= 1'b0;
			protect_flags[DATA_W-1:TOUCH_BIT+1] <= '0;
		end
	end

	// ****************************************************************
	// Register read
	// ****************************************************************
	// Data stand one cycle after the read strobe only; unmapped offsets read zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= ZERO_WORD;
		end else if (reg_re) begin
			case (reg_addr)
				OFF_PROTECT_CLEAR: begin
					reg_rdata <= flags & FLAG_MASK;
				end
				OFF_PROTECT_SET: begin
					reg_rdata <= flags & FLAG_MASK;
				end
				OFF_IRQ_STATUS: begin
					reg_rdata <= {{(DATA_W-IRQ_BITS){1'b0}}, irq_status_reg};
				end
				OFF_IRQ_MASK: begin
					reg_rdata <= {{(DATA_W-IRQ_BITS){1'b0}}, irq_mask_reg};
				end
				OFF_LAST_FAULT: begin
					reg_rdata <= last_fault_reg;
				end
				default: begin
					reg_rdata <= ZERO_WORD;
				end
			endcase
		end else begin
			reg_rdata <= ZERO_WORD;
		end
	end

endmodule : pwp_top

// >>> verif/pwp_top_sva.sv
/* Checker for the pwp_top ports: flag word updates, reads, write gate.
 * Assumes binding onto pwp_top, one clock and a synchronous reset. */
`timescale 1ns/1ps

module pwp_top_sva import pwp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [pwp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pwp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [pwp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic periph_we,
	input wire logic [pwp_pkg::DATA_W-1:0] periph_sel,
	input wire logic periph_we_gated,
	input wire logic periph_err,
	input wire logic [pwp_pkg::DATA_W-1:0] protect_flags,
	input wire logic irq
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Clear writes drop only the ones written; set writes land in the same word.
	a_clear_drops_flags: assert property (reg_we && reg_addr == OFF_PROTECT_CLEAR |=> ##1
		protect_flags == ($past(protect_flags) & ~$past(reg_wdata, 2) & FLAG_MASK))
		else $error("Clear write gave a wrong flag word.");
	a_set_shares_word: assert property (reg_we && reg_addr == OFF_PROTECT_SET |=> ##1
		protect_flags == (($past(protect_flags) | $past(reg_wdata, 2)) & FLAG_MASK))
		else $error("Set write gave a wrong flag word.");
	a_read_shows_flags: assert property (reg_re && (reg_addr == OFF_PROTECT_CLEAR ||
		reg_addr == OFF_PROTECT_SET) |=> reg_rdata == protect_flags)
		else $error("Flag read differs from the flag word.");
	a_no_stray_flags: assert property ((protect_flags & ~FLAG_MASK) == ZERO_WORD)
		else $error("A position without a peripheral shows a flag.");
	// The gate passes exactly the writes whose peripheral is unprotected.
	a_gate_follows_flag: assert property (periph_we |=>
		periph_we_gated == !(|($past(periph_sel) & protect_flags)))
		else $error("Write gate disagrees with the flag.");
	a_refused_gives_err: assert property (periph_we ##1 (|($past(periph_sel) & protect_flags))
		|=> periph_err)
		else $error("Refused write without bus error.");
	a_err_has_cause: assert property (periph_err |-> $past(periph_we, 2) && !$past(periph_we_gated))
		else $error("Bus error without a refused write.");
endmodule : pwp_top_sva

// >>> verif/pwp_top_bench.sv
/* Self-checking bench for pwp_top driven through its register and gate ports.
 * Assumes the pwp_pkg constants and the checker module pwp_top_sva. */
`timescale 1ns/1ps

module pwp_top_bench;
	import pwp_pkg::*;
	logic clk, rst, reg_we, reg_re, periph_we, periph_we_gated, periph_err, irq;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, periph_sel, protect_flags;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;

	pwp_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .periph_we(periph_we),
		.periph_sel(periph_sel), .periph_we_gated(periph_we_gated), .periph_err(periph_err),
		.protect_flags(protect_flags), .irq(irq));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// Compares a seen value against the expected one and counts both.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One write strobe, then an idle cycle so strobes never re-assign in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
		@(posedge clk);
	endtask : wr
	// One read strobe; data are checked in the following cycle only.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 chk(reg_rdata, exp);
		@(posedge clk);
	endtask : rd
	// Peripheral write to flag position n; e says whether it must be refused.
	task automatic pw(input int n, input logic e);
		periph_sel <= 32'h0000_0001 << n;
		periph_we <= 1'b1;
		@(posedge clk);
		periph_we <= 1'b0;
		#1 chk(32'(periph_we_gated), 32'(!e));
		@(posedge clk);
		#1 chk(32'(periph_err), 32'(e));
		@(posedge clk);
	endtask : pw
	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// ****************************************************************
	// Clock, timeout and tests
	// ****************************************************************
	// Free-running 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Cuts a hang short well beyond the expected run length.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			results;
		end
	end
	// Main sequence of register and gate tests.
	initial begin
		rst = 1'b1;
		reg_we = 1'b0;
		reg_re = 1'b0;
		periph_we = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		periph_sel = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_PROTECT_CLEAR, ZERO_WORD);
		wr(OFF_PROTECT_SET, 32'hffff_ffff);
		rd(OFF_PROTECT_CLEAR, FLAG_MASK);
		wr(OFF_PROTECT_CLEAR, 32'h0000_0000);
		wr(OFF_PROTECT_CLEAR, 32'hfff0_0001);
		rd(OFF_PROTECT_SET, FLAG_MASK);
		wr(OFF_PROTECT_CLEAR, 32'h0000_5554);
		rd(OFF_PROTECT_SET, 32'h000f_aaaa);
		chk(protect_flags, 32'h000f_aaaa);
		$display("test flag word done");
		wr(OFF_IRQ_MASK, 32'h0000_0001);
		rd(OFF_IRQ_MASK, 32'h0000_0001);
		for (int n = 2; n < 16; n++) pw(n, n[0]);
		chk(32'(irq), 32'h0000_0001);
		rd(OFF_IRQ_STATUS, 32'h0000_0001);
		wr(OFF_IRQ_STATUS, 32'h0000_0001);
		rd(OFF_IRQ_STATUS, ZERO_WORD);
		chk(32'(irq), ZERO_WORD);
		wr(OFF_IRQ_MASK, ZERO_WORD);
		pw(15, 1'b1);
		rd(OFF_IRQ_STATUS, 32'h0000_0001);
		chk(32'(irq), ZERO_WORD);
		rd(OFF_LAST_FAULT, 32'h0000_8000);
		rd(8'h20, ZERO_WORD);
		$display("test gate and interrupt done");
		results;
	end
endmodule : pwp_top_bench

bind pwp_top pwp_top_sva u_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.periph_we(periph_we), .periph_sel(periph_sel), .periph_we_gated(periph_we_gated),
	.periph_err(periph_err), .protect_flags(protect_flags), .irq(irq));
